// >>> rtl/alf_defs.svh
// Offsets, field positions, data-space addresses and masks of the flags block.
// Included by bare name; holds definitions only.
`ifndef ALF_DEFS_SVH
`define ALF_DEFS_SVH
`define ALF_OFF_FLAGS 8'h00
`define ALF_OFF_ACCUM 8'h04
`define ALF_OFF_BANK 8'h08
`define ALF_OFF_PTR0 8'h0C
`define ALF_OFF_PTR1 8'h10
`define ALF_OFF_PTR2 8'h14
`define ALF_OFF_CMD 8'h18
`define ALF_OFF_FULL_SRC 8'h1C
`define ALF_OFF_TARGET 8'h20
`define ALF_OFF_LAST_ADDR 8'h24
`define ALF_OFF_MEM_ADDR 8'h28
`define ALF_OFF_MEM_DATA 8'h2C
`define ALF_OFF_CONFIG 8'h30
`define ALF_FLG_C 0
`define ALF_FLG_DC 1
`define ALF_FLG_Z 2
`define ALF_FLG_OV 3
`define ALF_FLG_N 4
`define ALF_FLAGS_RST 5'h00
`define ALF_AFF_ALL 5'h1F
`define ALF_AFF_ZN 5'h14
`define ALF_AFF_ZNC 5'h15
`define ALF_AFF_Z 5'h04
`define ALF_AFF_NONE 5'h00
`define ALF_CMD_OP 31:27
`define ALF_CMD_FDST 26:15
`define ALF_CMD_TGT 19:0
`define ALF_CMD_BIT 12:10
`define ALF_CMD_A 9
`define ALF_CMD_D 8
`define ALF_CMD_F 7:0
`define ALF_CFG_EXT 0
`define ALF_FLAGS_FADDR 12'hFD8
`define ALF_IND_BASE0 12'hFEF
`define ALF_IND_BASE1 12'hFE7
`define ALF_IND_BASE2 12'hFDF
`define ALF_IND_SPAN 12'h004
`define ALF_IDX_MAX 8'h5F
`define ALF_ACC_HIGH 8'h60
`define ALF_ACC_BANK_HI 4'hF
`define ALF_ACC_BANK_LO 4'h0
`define ALF_KIND_INDF 3'h0
`define ALF_KIND_POST_INCREMENT_OPERAND 3'h1
`define ALF_KIND_POST_DECREMENT_OPERAND 3'h2
`define ALF_KIND_PRE_INCREMENT_OPERAND 3'h3
`define ALF_KIND_ACCUMULATOR_INDEXED_OPERAND 3'h4
`endif

// >>> rtl/alf_pkg.sv
// Types of the flags and data-addressing block.
// Opcode and bus-state values are set here; alf_defs.svh holds the other constants.
package alf_pkg;
  typedef enum logic [4:0] {
    ALF_OP_ADD = 5'h00,
    ALF_OP_SUB = 5'h01,
    ALF_OP_AND = 5'h02,
    ALF_OP_IOR = 5'h03,
    ALF_OP_XOR = 5'h04,
    ALF_OP_MOVF = 5'h05,
    ALF_OP_CLR = 5'h06,
    ALF_OP_ROTATE_LEFT = 5'h07,
    ALF_OP_ROTATE_RIGHT = 5'h08,
    ALF_OP_SWAP = 5'h09,
    ALF_OP_BIT_SET = 5'h0A,
    ALF_OP_BIT_CLEAR = 5'h0B,
    ALF_OP_ACC_STORE = 5'h0C,
    ALF_OP_FULL_MOVE = 5'h0D,
    ALF_OP_ADDLIT = 5'h0E,
    ALF_OP_SUBLIT = 5'h0F,
    ALF_OP_JUMP = 5'h10
  } alf_op_t;
  typedef enum logic [0:0] {
    ALF_BUS_IDLE = 1'b0,
    ALF_BUS_ANSWER = 1'b1
  } alf_bus_t;
  typedef struct packed {
    alf_bus_t bus;
    logic waitreq;
    logic [31:0] rdata;
    logic [4:0] flags;
    logic [7:0] accum;
    logic [3:0] bank;
    logic [2:0][11:0] ptr;
    logic [11:0] full_src;
    logic [19:0] jump_tgt;
    logic [11:0] last_addr;
    logic [11:0] mem_addr;
    logic ext_en;
    logic [31:0] cmd;
  } alf_state_t;
endpackage : alf_pkg

// >>> rtl/alf_core.sv
// Condition flags, operand address forming and pointer-based indirect access,
// run one command at a time from an Avalon-MM slave port.
// Assumes a synchronous Avalon-MM master on clk_i; data memory is internal.
//
// What this block does
// - Flags as destination of a flag-changing op: data dropped, flags updated.
// - Clearing the flag register sets zero only, other flags unchanged.
// - Negative flag, bit 4, follows result bit 7; bits 7 to 5 read zero.
// - Overflow flag, bit 3, set when signed result changes sign wrongly.
// - Zero flag, bit 2, set when the result is all zero.
// - Add and subtract set nibble carry, bit 1, from low-nibble carry.
// - Add and subtract set carry, bit 0, from carry out of bit 7.
// - Subtract adds the two's complement, so carries read as inverted borrows.
// - Rotates through carry load carry with the bit shifted out.
// - Jump commands carry a full 20-bit program target.
// - Banked direct access joins bank select with the 8-bit address.
// - Access-bank direct ignores bank select and uses the access bank.
// - Full-address moves use their 12-bit addresses with no bank select.
// - Destination bit: 1 writes back to the file, 0 to the accumulator.
// - Three 12-bit pointer pairs; upper high-byte bits unused.
// - Indirect operands reach the memory their pointer addresses.
// - Indirect addresses ignore bank select and the access bit.
// - Indexed literal offset only when extended mode is enabled.
// - Post operands adjust the pointer after access, pre-increment before.
// - Pointer steps carry across all 12 bits and touch no flag.
// - Indirect access aimed at another indirect operand reads zero, writes nothing.
// - Accumulator-indexed operand adds signed accumulator, changing neither.
`timescale 1ns/100ps
`default_nettype none
`include "alf_defs.svh"
module alf_core #(
  parameter int DEPTH = 4096
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [19:0] prog_target_o,
  output logic [11:0] data_addr_o
);
  import alf_pkg::*;

  localparam alf_state_t ALF_RST = '{bus: ALF_BUS_IDLE, waitreq: 1'b1, flags: `ALF_FLAGS_RST, default: '0};

  alf_state_t s;
  alf_state_t s_n;
  logic [7:0] mem [DEPTH];
  logic mem_we;
  logic [11:0] mem_wa;
  logic [7:0] mem_wd;
  logic [31:0] reg_rd;
  logic [31:0] wdata;
  logic [31:0] cmd;
  alf_op_t op;
  logic [7:0] fsel;
  logic exec;
  logic lit_op;
  logic file_op;
  logic [11:0] addr;
  logic hit;
  logic [1:0] idx;
  logic [2:0] kind;
  logic [11:0] ptr_cur;
  logic [11:0] ptr_upd;
  logic [11:0] tgt;
  logic tgt_virt;
  logic [7:0] fval;
  logic [7:0] opa;
  logic [7:0] bb;
  logic sub;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic [4:0] aff;
  logic [4:0] newf;
  logic to_file;
  logic fdest;
  logic [11:0] fdst;
  logic [7:0] sval;

  function automatic logic [11:0] ind_base(input int i);
    case (i)
      0: ind_base = `ALF_IND_BASE0;
      1: ind_base = `ALF_IND_BASE1;
      default: ind_base = `ALF_IND_BASE2;
    endcase
  endfunction : ind_base

  function automatic logic is_virtual(input logic [11:0] ad);
    is_virtual = 1'b0;
    for (int i = 0; i < 3; i++)
      if (ad <= ind_base(i) && ad >= ind_base(i) - `ALF_IND_SPAN)
        is_virtual = 1'b1;
  endfunction : is_virtual

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_n = s;
    mem_we = 1'b0;
    mem_wa = s.mem_addr;
    mem_wd = 8'h00;
    case (avs_address_i)
      `ALF_OFF_FLAGS: reg_rd = {27'h0, s.flags};
      `ALF_OFF_ACCUM: reg_rd = {24'h0, s.accum};
      `ALF_OFF_BANK: reg_rd = {28'h0, s.bank};
      `ALF_OFF_PTR0: reg_rd = {20'h0, s.ptr[0]};
      `ALF_OFF_PTR1: reg_rd = {20'h0, s.ptr[1]};
      `ALF_OFF_PTR2: reg_rd = {20'h0, s.ptr[2]};
      `ALF_OFF_CMD: reg_rd = s.cmd;
      `ALF_OFF_FULL_SRC: reg_rd = {20'h0, s.full_src};
      `ALF_OFF_TARGET: reg_rd = {12'h0, s.jump_tgt};
      `ALF_OFF_LAST_ADDR: reg_rd = {20'h0, s.last_addr};
      `ALF_OFF_MEM_ADDR: reg_rd = {20'h0, s.mem_addr};
      `ALF_OFF_MEM_DATA: reg_rd = {24'h0, mem[s.mem_addr]};
      `ALF_OFF_CONFIG: reg_rd = {31'h0, s.ext_en};
      default: reg_rd = 32'h0;
    endcase
    for (int i = 0; i < 4; i++)
      wdata[i*8 +: 8] = avs_byteenable_i[i] ? avs_writedata_i[i*8 +: 8] : reg_rd[i*8 +: 8];

    // Command decode is evaluated every cycle and only acted on under exec
    cmd = wdata;
    op = alf_op_t'(cmd[`ALF_CMD_OP]);
    fsel = cmd[`ALF_CMD_F];
    fdst = cmd[`ALF_CMD_FDST];
    exec = (s.bus == ALF_BUS_ANSWER) && avs_write_i && (avs_address_i == `ALF_OFF_CMD);
    lit_op = (op == ALF_OP_ADDLIT) || (op == ALF_OP_SUBLIT);
    file_op = !lit_op && (op != ALF_OP_JUMP) && (op != ALF_OP_FULL_MOVE);

    if (cmd[`ALF_CMD_A])
      addr = {s.bank, fsel};
    else if (s.ext_en && fsel <= `ALF_IDX_MAX)
      addr = s.ptr[2] + {4'h0, fsel};
    else if (fsel >= `ALF_ACC_HIGH)
      addr = {`ALF_ACC_BANK_HI, fsel};
    else
      addr = {`ALF_ACC_BANK_LO, fsel};

    hit = 1'b0;
    idx = 2'd0;
    kind = `ALF_KIND_INDF;
    for (int i = 0; i < 3; i++)
      if (addr <= ind_base(i) && addr >= ind_base(i) - `ALF_IND_SPAN)
      begin
        hit = 1'b1;
        idx = 2'(i);
        kind = 3'(ind_base(i) - addr);
      end
    ptr_cur = s.ptr[idx];
    ptr_upd = ptr_cur;
    tgt = addr;
    // Whole pointer is the address; bank select and access bit play no part
    if (hit)
      case (kind)
        `ALF_KIND_POST_INCREMENT_OPERAND:
        begin
          tgt = ptr_cur;
          ptr_upd = ptr_cur + 12'h001;
        end
        `ALF_KIND_POST_DECREMENT_OPERAND:
        begin
          tgt = ptr_cur;
          ptr_upd = ptr_cur - 12'h001;
        end
        `ALF_KIND_PRE_INCREMENT_OPERAND:
        begin
          ptr_upd = ptr_cur + 12'h001;
          tgt = ptr_upd;
        end
        `ALF_KIND_ACCUMULATOR_INDEXED_OPERAND: tgt = ptr_cur + {{4{s.accum[7]}}, s.accum};
        default: tgt = ptr_cur;
      endcase
    tgt_virt = hit && is_virtual(tgt);
    if (tgt_virt)
      fval = 8'h00;
    else if (tgt == `ALF_FLAGS_FADDR)
      fval = {3'b000, s.flags};
    else
      fval = mem[tgt];
    if (is_virtual(s.full_src))
      sval = 8'h00;
    else if (s.full_src == `ALF_FLAGS_FADDR)
      sval = {3'b000, s.flags};
    else
      sval = mem[s.full_src];

    ////////////////////////////////////////////////////////////////////////////
    opa = lit_op ? fsel : fval;
    sub = (op == ALF_OP_SUB) || (op == ALF_OP_SUBLIT);
    bb = sub ? ~s.accum : s.accum;
    sum9 = {1'b0, opa} + {1'b0, bb} + {8'h00, sub};
    sum5 = {1'b0, opa[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    res = 8'h00;
    aff = `ALF_AFF_NONE;
    newf = s.flags;
    case (op)
      ALF_OP_ADD, ALF_OP_SUB, ALF_OP_ADDLIT, ALF_OP_SUBLIT:
      begin
        res = sum9[7:0];
        aff = `ALF_AFF_ALL;
        newf[`ALF_FLG_C] = sum9[8];
        newf[`ALF_FLG_DC] = sum5[4];
        newf[`ALF_FLG_OV] = (opa[7] == bb[7]) && (sum9[7] != opa[7]);
      end
      ALF_OP_AND:
      begin
        res = opa & s.accum;
        aff = `ALF_AFF_ZN;
      end
      ALF_OP_IOR:
      begin
        res = opa | s.accum;
        aff = `ALF_AFF_ZN;
      end
      ALF_OP_XOR:
      begin
        res = opa ^ s.accum;
        aff = `ALF_AFF_ZN;
      end
      ALF_OP_MOVF:
      begin
        res = opa;
        aff = `ALF_AFF_ZN;
      end
      ALF_OP_CLR: aff = `ALF_AFF_Z;
      ALF_OP_ROTATE_LEFT:
      begin
        res = {opa[6:0], s.flags[`ALF_FLG_C]};
        newf[`ALF_FLG_C] = opa[7];
        aff = `ALF_AFF_ZNC;
      end
      ALF_OP_ROTATE_RIGHT:
      begin
        res = {s.flags[`ALF_FLG_C], opa[7:1]};
        newf[`ALF_FLG_C] = opa[0];
        aff = `ALF_AFF_ZNC;
      end
      ALF_OP_SWAP: res = {opa[3:0], opa[7:4]};
      ALF_OP_BIT_SET: res = opa | (8'h01 << cmd[`ALF_CMD_BIT]);
      ALF_OP_BIT_CLEAR: res = opa & ~(8'h01 << cmd[`ALF_CMD_BIT]);
      ALF_OP_ACC_STORE: res = s.accum;
      ALF_OP_FULL_MOVE: res = sval;
      default: res = 8'h00;
    endcase
    newf[`ALF_FLG_Z] = (res == 8'h00);
    newf[`ALF_FLG_N] = res[7];
    to_file = file_op && (cmd[`ALF_CMD_D] || op == ALF_OP_CLR || op == ALF_OP_BIT_SET ||
                          op == ALF_OP_BIT_CLEAR || op == ALF_OP_ACC_STORE);
    fdest = to_file && (tgt == `ALF_FLAGS_FADDR);

    ////////////////////////////////////////////////////////////////////////////
    // One wait cycle per access; the answer is registered so outputs stay clean
    case (s.bus)
      ALF_BUS_IDLE:
        if (avs_read_i || avs_write_i)
        begin
          s_n.bus = ALF_BUS_ANSWER;
          s_n.waitreq = 1'b0;
          s_n.rdata = reg_rd;
        end
      ALF_BUS_ANSWER:
      begin
        s_n.bus = ALF_BUS_IDLE;
        s_n.waitreq = 1'b1;
        if (avs_write_i)
          case (avs_address_i)
            `ALF_OFF_FLAGS: s_n.flags = wdata[4:0];
            `ALF_OFF_ACCUM: s_n.accum = wdata[7:0];
            `ALF_OFF_BANK: s_n.bank = wdata[3:0];
            `ALF_OFF_PTR0: s_n.ptr[0] = wdata[11:0];
            `ALF_OFF_PTR1: s_n.ptr[1] = wdata[11:0];
            `ALF_OFF_PTR2: s_n.ptr[2] = wdata[11:0];
            `ALF_OFF_CMD: s_n.cmd = wdata;
            `ALF_OFF_FULL_SRC: s_n.full_src = wdata[11:0];
            `ALF_OFF_MEM_ADDR: s_n.mem_addr = wdata[11:0];
            `ALF_OFF_MEM_DATA:
            begin
              mem_we = 1'b1;
              mem_wd = wdata[7:0];
            end
            `ALF_OFF_CONFIG: s_n.ext_en = wdata[`ALF_CFG_EXT];
            default: s_n.bus = ALF_BUS_IDLE;
          endcase
      end
      default: s_n.bus = ALF_BUS_IDLE;
    endcase

    if (exec)
    begin
      s_n.last_addr = tgt;
      if (file_op && hit)
        s_n.ptr[idx] = ptr_upd;
      s_n.flags = (s.flags & ~aff) | (newf & aff);
      // Data result is dropped when flags are both target and changed
      if (fdest && aff == `ALF_AFF_NONE)
        s_n.flags = res[4:0];
      else if (to_file && !fdest && !tgt_virt)
      begin
        mem_we = 1'b1;
        mem_wa = tgt;
        mem_wd = res;
      end
      if (!to_file && (file_op || lit_op))
        s_n.accum = res;
      if (op == ALF_OP_JUMP)
        s_n.jump_tgt = cmd[`ALF_CMD_TGT];
      if (op == ALF_OP_FULL_MOVE)
      begin
        s_n.last_addr = fdst;
        if (fdst == `ALF_FLAGS_FADDR)
          s_n.flags = sval[4:0];
        else if (!is_virtual(fdst))
        begin
          mem_we = 1'b1;
          mem_wa = fdst;
          mem_wd = sval;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s <= ALF_RST;
    else
      s <= s_n;
  end

  // Data memory has no reset: contents are unknown until written
  always_ff @(posedge clk_i)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = s.waitreq;
  assign prog_target_o = s.jump_tgt;
  assign data_addr_o = s.last_addr;

  //////////////////////////////////////////////////////////////////////////////
  default clocking alf_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic flg_chk;
  logic [8:0] add_ref;
  assign flg_chk = exec && !fdest;
  assign add_ref = {1'b0, opa} + {1'b0, s.accum};

  sequence req_seen_s;
    (s.bus == ALF_BUS_IDLE) && (avs_read_i || avs_write_i);
  endsequence
  sequence answer_s;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  bus_answer_a: assert property (req_seen_s |=> answer_s)
    else $error("bus answer is not a single low waitrequest cycle");
  flag_dest_a: assert property (exec && fdest && aff != `ALF_AFF_NONE |-> !mem_we ##1 s.accum == $past(s.accum))
    else $error("result stored while flags were the destination");
  clear_flags_a: assert property (exec && fdest && op == ALF_OP_CLR |=> s.flags == ($past(s.flags) | `ALF_AFF_Z))
    else $error("clearing flags did not give zero set and others kept");
  neg_zero_a: assert property (flg_chk && aff == `ALF_AFF_ALL |=> s.flags[`ALF_FLG_N] == $past(res[7]) && s.flags[`ALF_FLG_Z] == ($past(res) == 8'h00))
    else $error("negative or zero flag wrong");
  overflow_a: assert property (flg_chk && op == ALF_OP_ADD |=> s.flags[`ALF_FLG_OV] == $past(opa[7] == s.accum[7] && add_ref[7] != opa[7]))
    else $error("overflow flag wrong after add");
  nibble_carry_a: assert property (flg_chk && op == ALF_OP_ADD |=> s.flags[`ALF_FLG_DC] == $past(opa[3:0] > (4'hF - s.accum[3:0])))
    else $error("nibble carry wrong after add");
  add_carry_a: assert property (flg_chk && op == ALF_OP_ADD |=> s.flags[`ALF_FLG_C] == $past(add_ref[8]))
    else $error("carry wrong after add");
  sub_borrow_a: assert property (flg_chk && op == ALF_OP_SUB |=> s.flags[`ALF_FLG_C] == $past(opa >= s.accum))
    else $error("carry is not inverted borrow after subtract");
  rotate_carry_a: assert property (exec && op == ALF_OP_ROTATE_RIGHT |=> s.flags[`ALF_FLG_C] == $past(opa[0]))
    else $error("rotate right did not load carry from bit 0");
  jump_target_a: assert property (exec && op == ALF_OP_JUMP |=> prog_target_o == $past(cmd[`ALF_CMD_TGT]))
    else $error("jump target not captured");
  bank_addr_a: assert property (exec && cmd[`ALF_CMD_A] |-> addr == {s.bank, fsel})
    else $error("banked address not formed from bank select");
  access_bank_a: assert property (exec && !cmd[`ALF_CMD_A] && fsel >= `ALF_ACC_HIGH |-> addr[11:8] == `ALF_ACC_BANK_HI)
    else $error("access bank address wrong");
  full_move_a: assert property (exec && op == ALF_OP_FULL_MOVE && mem_we |-> mem_wa == fdst)
    else $error("full move wrote another address");
  dest_accum_a: assert property (exec && file_op && !to_file |-> !mem_we ##1 s.accum == $past(res))
    else $error("destination bit zero did not load accumulator");
  post_inc_a: assert property (exec && file_op && hit && kind == `ALF_KIND_POST_INCREMENT_OPERAND |-> tgt == ptr_cur ##1 s.ptr[$past(idx)] == $past(ptr_cur) + 12'h001)
    else $error("post increment order or carry wrong");
  indexed_keep_a: assert property (exec && file_op && to_file && hit && kind == `ALF_KIND_ACCUMULATOR_INDEXED_OPERAND |=> s.ptr[$past(idx)] == $past(ptr_cur) && s.accum == $past(s.accum))
    else $error("indexed operand changed pointer or accumulator");
  virtual_null_a: assert property (exec && tgt_virt |-> fval == 8'h00 && !(mem_we && mem_wa == tgt))
    else $error("indirect access to an indirect operand not nulled");
endmodule : alf_core
`default_nettype wire

// >>> testbench/alf_core_tb.sv
// Self-checking bench for alf_core: drives the Avalon-MM port and checks read data.
// Assumes the register map and command layout of alf_defs.svh; no checker, no partner.
`timescale 1ns/100ps
`default_nettype none
`include "alf_defs.svh"
module alf_core_tb;
  import alf_pkg::*;
  logic clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0] avs_byteenable_i;
  logic [19:0] prog_target_o;
  logic [11:0] data_addr_o;
  logic [31:0] exp_q[$];
  int n_fail, checked;

  alf_core u_alf_core (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .prog_target_o(prog_target_o), .data_addr_o(data_addr_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk

  // Trailing edge after release so the next request never lands in the same step
  // No local limit on the wait: a slave that never answers is caught by the watchdog
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_i);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic poke(input logic [11:0] a, input logic [7:0] v);
    wr(`ALF_OFF_MEM_ADDR, {20'h0, a});
    wr(`ALF_OFF_MEM_DATA, {24'h0, v});
  endtask : poke

  task automatic peek(input logic [11:0] a, input logic [7:0] v);
    wr(`ALF_OFF_MEM_ADDR, {20'h0, a});
    rd(`ALF_OFF_MEM_DATA, {24'h0, v});
  endtask : peek

  task automatic cmd(input logic [4:0] op, input logic a, input logic d, input logic [7:0] f);
    logic [31:0] w;
    w = 32'h0;
    w[`ALF_CMD_OP] = op;
    w[`ALF_CMD_A] = a;
    w[`ALF_CMD_D] = d;
    w[`ALF_CMD_F] = f;
    bus(1'b1, `ALF_OFF_CMD, w);
  endtask : cmd

  // Returns {result, n, ov, z, dc, c}; subtraction passes the inverted operand and carry-in 1
  function automatic logic [12:0] arith(input logic [7:0] x, input logic [7:0] y, input logic ci);
    logic [8:0] s;
    logic [4:0] lo;
    s = {1'b0, x} + {1'b0, y} + {8'h0, ci};
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    return {s[7:0], s[7], (x[7] == y[7]) && (s[7] != x[7]), s[7:0] == 8'h0, lo[4], s[8]};
  endfunction : arith

  always @(posedge clk_i)
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
    begin
      if (exp_q.size() == 0) n_fail++;
      else chk(avs_readdata_o, exp_q.pop_front());
    end

  task automatic results;
    if (exp_q.size() != 0) n_fail++;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    results();
  end

  initial
  begin
    int i;
    logic [7:0] x, w;
    logic [12:0] r;
    logic [19:0] t;
    logic [4:0] o;
    rst_i = 1'b1;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
    avs_byteenable_i = 4'hF;
    n_fail = 0;
    checked = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    void'($urandom(32'hD3B3));
    rd(`ALF_OFF_FLAGS, 32'h0);
    rd(`ALF_OFF_TARGET, 32'h0);
    wr(`ALF_OFF_FLAGS, 32'hFF);
    rd(`ALF_OFF_FLAGS, 32'h1F);
    wr(`ALF_OFF_PTR0, 32'hFFFF);
    rd(`ALF_OFF_PTR0, 32'hFFF);
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0);
    $display("reset and map test done");
    wr(`ALF_OFF_BANK, 32'h2);
    for (i = 0; i < 24; i++)
    begin
      x = (i == 0) ? 8'h80 : 8'($urandom());
      w = (i == 0) ? 8'h80 : 8'($urandom());
      poke(12'h230, x);
      wr(`ALF_OFF_ACCUM, {24'h0, w});
      cmd(i[0] ? ALF_OP_SUB : ALF_OP_ADD, 1'b1, i[1], 8'h30);
      r = i[0] ? arith(x, ~w, 1'b1) : arith(x, w, 1'b0);
      rd(`ALF_OFF_FLAGS, {27'h0, r[4:0]});
      rd(`ALF_OFF_ACCUM, {24'h0, i[1] ? w : r[12:5]});
      peek(12'h230, i[1] ? r[12:5] : x);
      rd(`ALF_OFF_LAST_ADDR, 32'h230);
      chk({20'h0, data_addr_o}, 32'h230);
    end
    $display("arithmetic test done");
    for (i = 0; i < 10; i++)
    begin
      x = 8'($urandom());
      w = 8'($urandom());
      o = (i % 5 == 0) ? ALF_OP_AND : (i % 5 == 1) ? ALF_OP_IOR : (i % 5 == 2) ? ALF_OP_XOR :
          (i % 5 == 3) ? ALF_OP_ADDLIT : ALF_OP_SUBLIT;
      r = (o == ALF_OP_SUBLIT) ? arith(x, ~w, 1'b1) : arith(x, w, 1'b0);
      // Logic ops touch zero and negative only; the others stay at the cleared value
      if (i % 5 < 3)
      begin
        r[12:5] = (o == ALF_OP_AND) ? (x & w) : (o == ALF_OP_IOR) ? (x | w) : (x ^ w);
        r[4:0] = {r[12], 1'b0, r[12:5] == 8'h0, 2'b00};
      end
      poke(12'h230, x);
      wr(`ALF_OFF_ACCUM, {24'h0, w});
      wr(`ALF_OFF_FLAGS, 32'h0);
      cmd(o, 1'b1, 1'b0, (i % 5 < 3) ? 8'h30 : x);
      rd(`ALF_OFF_ACCUM, {24'h0, r[12:5]});
      rd(`ALF_OFF_FLAGS, {27'h0, r[4:0]});
    end
    $display("logic and literal test done");
    wr(`ALF_OFF_PTR2, 32'h123);
    for (i = 0; i < 4; i++)
    begin
      wr(`ALF_OFF_CONFIG, {31'h0, i[1]});
      // File destination: these locations were never written, so the accumulator stays known
      cmd(ALF_OP_MOVF, 1'b0, 1'b1, i[0] ? 8'h70 : 8'h20);
      rd(`ALF_OFF_LAST_ADDR, i[0] ? 32'hF70 : (i[1] ? 32'h143 : 32'h020));
    end
    wr(`ALF_OFF_CONFIG, 32'h0);
    $display("access bank test done");
    wr(`ALF_OFF_FLAGS, 32'h1B);
    cmd(ALF_OP_CLR, 1'b0, 1'b1, 8'hD8);
    rd(`ALF_OFF_FLAGS, 32'h1F);
    wr(`ALF_OFF_FLAGS, 32'h0);
    wr(`ALF_OFF_ACCUM, 32'h1);
    cmd(ALF_OP_ADD, 1'b0, 1'b1, 8'hD8);
    rd(`ALF_OFF_FLAGS, 32'h0);
    poke(12'h230, 8'h81);
    cmd(ALF_OP_ROTATE_LEFT, 1'b1, 1'b0, 8'h30);
    rd(`ALF_OFF_ACCUM, 32'h02);
    rd(`ALF_OFF_FLAGS, 32'h01);
    cmd(ALF_OP_ROTATE_RIGHT, 1'b1, 1'b0, 8'h30);
    rd(`ALF_OFF_ACCUM, 32'hC0);
    rd(`ALF_OFF_FLAGS, 32'h11);
    wr(`ALF_OFF_CMD, {ALF_OP_BIT_SET, 14'h0, 3'h3, 2'b00, 8'hD8});
    rd(`ALF_OFF_FLAGS, 32'h19);
    cmd(ALF_OP_BIT_CLEAR, 1'b0, 1'b0, 8'hD8);
    rd(`ALF_OFF_FLAGS, 32'h18);
    cmd(ALF_OP_SWAP, 1'b0, 1'b1, 8'hD8);
    rd(`ALF_OFF_FLAGS, 32'h01);
    $display("flag register test done");
    t = 20'($urandom());
    wr(`ALF_OFF_CMD, {ALF_OP_JUMP, 7'h0, t});
    rd(`ALF_OFF_TARGET, {12'h0, t});
    chk({12'h0, prog_target_o}, {12'h0, t});
    poke(12'h230, 8'h6E);
    wr(`ALF_OFF_FULL_SRC, 32'h230);
    wr(`ALF_OFF_BANK, 32'h7);
    wr(`ALF_OFF_CMD, {ALF_OP_FULL_MOVE, 12'h345, 15'h0});
    peek(12'h345, 8'h6E);
    $display("jump and full move test done");
    poke(12'h0FF, 8'hA5);
    poke(12'h102, 8'h3C);
    wr(`ALF_OFF_PTR0, 32'h0FF);
    wr(`ALF_OFF_BANK, 32'hF);
    cmd(ALF_OP_MOVF, 1'b1, 1'b0, 8'hEE);
    rd(`ALF_OFF_ACCUM, 32'hA5);
    rd(`ALF_OFF_PTR0, 32'h100);
    wr(`ALF_OFF_FLAGS, 32'h0A);
    cmd(ALF_OP_ACC_STORE, 1'b0, 1'b1, 8'hEE);
    rd(`ALF_OFF_FLAGS, 32'h0A);
    peek(12'h100, 8'hA5);
    cmd(ALF_OP_MOVF, 1'b0, 1'b0, 8'hEC);
    rd(`ALF_OFF_ACCUM, 32'h3C);
    cmd(ALF_OP_MOVF, 1'b0, 1'b0, 8'hED);
    rd(`ALF_OFF_PTR0, 32'h101);
    wr(`ALF_OFF_ACCUM, 32'hFF);
    cmd(ALF_OP_MOVF, 1'b0, 1'b0, 8'hEB);
    rd(`ALF_OFF_ACCUM, 32'hA5);
    rd(`ALF_OFF_PTR0, 32'h101);
    cmd(ALF_OP_ACC_STORE, 1'b0, 1'b1, 8'hEB);
    peek(12'h0A6, 8'hA5);
    rd(`ALF_OFF_PTR0, 32'h101);
    rd(`ALF_OFF_ACCUM, 32'hA5);
    wr(`ALF_OFF_PTR0, 32'hFE7);
    wr(`ALF_OFF_PTR1, 32'h0FF);
    cmd(ALF_OP_MOVF, 1'b0, 1'b0, 8'hEF);
    rd(`ALF_OFF_ACCUM, 32'h0);
    wr(`ALF_OFF_ACCUM, 32'h99);
    cmd(ALF_OP_ACC_STORE, 1'b0, 1'b1, 8'hEF);
    peek(12'h0FF, 8'hA5);
    $display("indirect test done");
    results();
  end
endmodule : alf_core_tb
`default_nettype wire
